/* File: shared/fic_map.svh */
// offsets, field positions, reset values and fixed numbers of the interrupt controller
`ifndef FIC_MAP_SVH
`define FIC_MAP_SVH

`define FIC_NSRC            24
`define FIC_ADDR_W          8
`define FIC_DATA_W          32

// register byte offsets
`define FIC_OFS_CTRL        8'h00
`define FIC_OFS_ENABLE      8'h04
`define FIC_OFS_PRIO_LOW    8'h08
`define FIC_OFS_PRIO_HIGH   8'h0c
`define FIC_OFS_FLAGS       8'h10
`define FIC_OFS_PENDING     8'h14
`define FIC_OFS_ACTIVE      8'h18
`define FIC_OFS_EVT_STATUS  8'h1c
`define FIC_OFS_EVT_ENABLE  8'h20
`define FIC_OFS_EVT_CLEAR   8'h24

// control register fields
`define FIC_CTRL_GLOBAL_BIT 0
`define FIC_CTRL_TXSF_BIT   1
`define FIC_CTRL_TRIG_LSB   4

// flag register fields: ext flags 3:0, timer flags 5:4
`define FIC_FLAGS_EXT_LSB   0
`define FIC_FLAGS_TMR_LSB   4

// active register fields: in-service levels 3:0, presented index 12:8
`define FIC_ACT_INSVC_LSB   0
`define FIC_ACT_IDX_LSB     8

// event bits
`define FIC_EVT_VECTORED    0
`define FIC_EVT_PREEMPT     1
`define FIC_EVT_BAD_RETURN  2
`define FIC_NEVT            3

// source indices (0 is source #1)
`define FIC_SRC_EXT0        5'h00
`define FIC_SRC_TMR0        5'h01
`define FIC_SRC_EXT1        5'h02
`define FIC_SRC_TMR1        5'h03
`define FIC_SRC_EXT2        5'h06
`define FIC_SRC_EXT3        5'h07

// vector addresses
`define FIC_VEC_BASE        16'h0003
`define FIC_VEC_STEP_SHIFT  3

`define FIC_RST_WORD        32'h0000_0000

`endif

/* File: shared/fic_pkg.sv */
// types of the interrupt controller
package fic_pkg;

  // event flags owned by the peripherals; each is a level while set
  typedef struct packed {
    logic       serial0_rx_flag;
    logic       serial0_tx_flag;
    logic [1:0] timer2_flags;
    logic [2:0] timer3_flags;
    logic [2:0] timer4_flags;
    logic [1:0] serial1_flags;
    logic [1:0] serial2_flags;
    logic [1:0] serial3_flags;
    logic       spi_flag;
    logic       adc_flag;
    logic [6:0] pca0_flags;
    logic [6:0] pca1_flags;
    logic       keypad_flag;
    logic       twsi_flag;
    logic       twi1_flag;
    logic       comp0_flag;
    logic       comp1_flag;
    logic       comp2_flag;
    logic       watchdog_event_flag;
    logic       brownout0_flag;
    logic       brownout1_flag;
    logic       rtc_overflow_flag;
    logic       missing_clock_flag;
    logic       serial_start_detect_flag;
    logic       serial_stop_detect_flag;
  } fic_periph_flags_t;

  typedef logic [1:0] fic_level_t;

  // what the core sees
  typedef struct packed {
    logic        req;
    fic_level_t  level;
    logic [4:0]  idx;
    logic [15:0] addr;
  } fic_vector_t;

endpackage

/* File: verilog/fic_arbiter.sv */
// picks the highest-level pending source, lowest index on a tie
`timescale 1ns/100ps
`default_nettype none

module fic_arbiter #(
  parameter int NSRC = 24
) (
  input  wire logic [NSRC-1:0]         req,        // gated requests
  input  wire logic [NSRC-1:0]         prio_low,   // low-order priority bits
  input  wire logic [NSRC-1:0]         prio_high,  // high-order priority bits
  output logic                         found,      // some request pending
  output logic [$clog2(NSRC)-1:0]      idx,        // winning source
  output fic_pkg::fic_level_t          level       // its level
);

  fic_pkg::fic_level_t lvl [NSRC];

  for (genvar i = 0; i < NSRC; i++) begin : g_lvl
    assign lvl[i] = {prio_high[i], prio_low[i]};
  end

  // scan upward, replace only on a strictly higher level so the lower index keeps a tie
  always_comb begin
    found = 1'b0;
    idx   = '0;
    level = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && (!found || lvl[i] > level)) begin
        found = 1'b1;
        idx   = ($clog2(NSRC))'(i);
        level = lvl[i];
      end
    end
  end

endmodule

`default_nettype wire

/* File: verilog/fic_top.sv */
// four-level interrupt controller: flags, enables, priorities, vectoring
// Notes on behaviour
// - 24 sources arbitrated over four levels
// - interrupt needs source enable and global enable
// - software flag writes act like hardware, except on level-triggered external flags, which follow the pin
// - level is high bit above low bit
// - ties go to the lowest source number
// - vector is 0003h plus eight per source
// - system source ORs its flags, tx optional
// - each external input level or edge
// - edge external flag cleared on vectoring
// - timer 0/1 flags cleared on vectoring
// - serial flags never cleared on vectoring
// - global enable low blocks every source
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fic_map.svh"

module fic_top #(
  parameter int NSRC = `FIC_NSRC
) (
  input  wire logic                       clk,            // 25 MHz core clock
  input  wire logic                       srst,           // synchronous reset
  input  wire logic                       ce,             // clock enable, freezes all
  input  wire logic [`FIC_ADDR_W-1:0]     addr,           // register byte address
  input  wire logic [`FIC_DATA_W-1:0]     wdata,          // write data
  input  wire logic                       wr,             // write strobe
  input  wire logic                       rd,             // read strobe
  output logic      [`FIC_DATA_W-1:0]     rdata,          // read data, cycle after rd
  input  wire logic                       ext_irq_pin_0,  // external input 0, active low
  input  wire logic                       ext_irq_pin_1,  // external input 1, active low
  input  wire logic                       ext_irq_pin_2,  // external input 2, active low
  input  wire logic                       ext_irq_pin_3,  // external input 3, active low
  input  wire logic                       timer0_rollover, // timer 0 overflow pulse
  input  wire logic                       timer1_rollover, // timer 1 overflow pulse
  input  wire fic_pkg::fic_periph_flags_t periph,         // peripheral flag levels
  output fic_pkg::fic_vector_t            vec,            // request to the core
  input  wire logic                       core_ack,       // core vectors to vec
  input  wire logic                       core_reti,      // core returns from a routine
  output logic                            irq_out         // event interrupt, level
);

  localparam int IW = $clog2(NSRC);

  // ---------------- register state
  logic            global_irq_enable, next_global;
  logic            tx_to_sysflag, next_tx_to_sysflag;
  logic [3:0]      ext_trigger_type, next_trigger;   // 1 = edge
  logic [NSRC-1:0] enable, next_enable;
  logic [NSRC-1:0] prio_low, next_prio_low;
  logic [NSRC-1:0] prio_high, next_prio_high;
  logic [3:0]      ext_request_flag, next_ext_flag;
  logic [1:0]      timer_overflow_flag, next_tmr_flag;
  logic [3:0]      pin_q, next_pin_q;
  logic [3:0]      in_service, next_in_service;
  logic [`FIC_NEVT-1:0] evt_status, next_evt_status;
  logic [`FIC_NEVT-1:0] evt_enable, next_evt_enable;
  logic [`FIC_NEVT-1:0] evt_set;
  logic [`FIC_DATA_W-1:0] next_rdata;
  logic            next_irq_out;
  fic_pkg::fic_vector_t next_vec;

  logic [3:0]      pin_now;
  logic [NSRC-1:0] src;
  logic [NSRC-1:0] gated;
  logic            win_found;
  logic [IW-1:0]   win_idx;
  fic_pkg::fic_level_t win_level;
  logic            have_svc;
  fic_pkg::fic_level_t svc_top;
  logic            eligible;
  logic            sysflag;
  logic [4:0]      ext_src [4];

  assign pin_now    = {ext_irq_pin_3, ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0};
  assign ext_src[0] = `FIC_SRC_EXT0;
  assign ext_src[1] = `FIC_SRC_EXT1;
  assign ext_src[2] = `FIC_SRC_EXT2;
  assign ext_src[3] = `FIC_SRC_EXT3;

  // ---------------- request vector
  assign sysflag = periph.watchdog_event_flag | periph.brownout0_flag
                 | periph.brownout1_flag | periph.rtc_overflow_flag
                 | periph.missing_clock_flag | periph.serial_start_detect_flag
                 | periph.serial_stop_detect_flag
                 | (tx_to_sysflag & periph.serial0_tx_flag);

  // peripheral-held flags are only read here, so vectoring never clears them
  always_comb begin
    src     = '0;
    src[0]  = ext_request_flag[0];
    src[1]  = timer_overflow_flag[0];
    src[2]  = ext_request_flag[1];
    src[3]  = timer_overflow_flag[1];
    src[4]  = periph.serial0_rx_flag | periph.serial0_tx_flag;
    src[5]  = |periph.timer2_flags;
    src[6]  = ext_request_flag[2];
    src[7]  = ext_request_flag[3];
    src[8]  = periph.spi_flag;
    src[9]  = periph.adc_flag;
    src[10] = |periph.pca0_flags;
    src[11] = sysflag;
    src[12] = |periph.serial1_flags;
    src[13] = periph.keypad_flag;
    src[14] = periph.twsi_flag;
    src[15] = periph.comp0_flag;
    src[16] = |periph.timer3_flags;
    src[17] = periph.comp1_flag;
    src[18] = |periph.serial2_flags;
    src[19] = |periph.timer4_flags;
    src[20] = |periph.serial3_flags;
    src[21] = |periph.pca1_flags;
    src[22] = periph.twi1_flag;
    src[23] = periph.comp2_flag;
  end

  assign gated = src & enable & {NSRC{global_irq_enable}};

  fic_arbiter #(
    .NSRC      (NSRC)
  ) u_arb (
    .req       (gated),
    .prio_low  (prio_low),
    .prio_high (prio_high),
    .found     (win_found),
    .idx       (win_idx),
    .level     (win_level)
  );

  // ---------------- nesting
  always_comb begin
    have_svc = |in_service;
    svc_top  = '0;
    for (int l = 0; l < 4; l++) begin
      if (in_service[l]) begin
        svc_top = fic_fixed_level(l);
      end
    end
  end

  function automatic fic_pkg::fic_level_t fic_fixed_level(input int l);
    fic_fixed_level = l[1:0];
  endfunction

  assign eligible = win_found && (!have_svc || win_level > svc_top);

  // ---------------- core handshake and in-service levels
  always_comb begin
    next_vec         = vec;
    next_in_service  = in_service;
    next_evt_status  = evt_status;
    evt_set          = '0;
    if (core_reti) begin
      if (!have_svc) begin
        evt_set[`FIC_EVT_BAD_RETURN] = 1'b1;
      end
      next_in_service[svc_top] = 1'b0;
    end
    if (core_ack && vec.req) begin
      next_in_service[vec.level] = 1'b1;
      evt_set[`FIC_EVT_VECTORED] = 1'b1;
      if (have_svc) begin
        evt_set[`FIC_EVT_PREEMPT] = 1'b1;
      end
    end
    // dropping req for the ack cycle keeps one request from being taken twice
    next_vec.req   = eligible && !core_ack;
    next_vec.level = win_level;
    next_vec.idx   = 5'(win_idx);
    next_vec.addr  = `FIC_VEC_BASE + (16'(win_idx) << `FIC_VEC_STEP_SHIFT);
    if (wr && addr == `FIC_OFS_EVT_CLEAR) begin
      next_evt_status = evt_status & ~wdata[`FIC_NEVT-1:0];
    end
    // set wins: an event landing in the clear cycle must not be lost
    next_evt_status = next_evt_status | evt_set;
  end

  // ---------------- flags held here
  always_comb begin
    next_pin_q    = pin_now;
    next_ext_flag = ext_request_flag;
    next_tmr_flag = timer_overflow_flag;
    if (wr && addr == `FIC_OFS_FLAGS) begin
      next_ext_flag = wdata[`FIC_FLAGS_EXT_LSB +: 4];
      next_tmr_flag = wdata[`FIC_FLAGS_TMR_LSB +: 2];
    end
    if (core_ack && vec.req) begin
      if (vec.idx == `FIC_SRC_TMR0) begin
        next_tmr_flag[0] = 1'b0;
      end
      if (vec.idx == `FIC_SRC_TMR1) begin
        next_tmr_flag[1] = 1'b0;
      end
    end
    if (timer0_rollover) begin
      next_tmr_flag[0] = 1'b1;
    end
    if (timer1_rollover) begin
      next_tmr_flag[1] = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      if (ext_trigger_type[i]) begin
        if (core_ack && vec.req && vec.idx == ext_src[i]) begin
          next_ext_flag[i] = 1'b0;
        end
        if (pin_q[i] && !pin_now[i]) begin
          next_ext_flag[i] = 1'b1;
        end
      end else begin
        // the pin owns the flag; it stays set until the source lets go
        next_ext_flag[i] = !pin_now[i];
      end
    end
  end

  // ---------------- register writes and reads
  always_comb begin
    next_global        = global_irq_enable;
    next_tx_to_sysflag = tx_to_sysflag;
    next_trigger       = ext_trigger_type;
    next_enable        = enable;
    next_prio_low      = prio_low;
    next_prio_high     = prio_high;
    next_evt_enable    = evt_enable;
    if (wr) begin
      case (addr)
        `FIC_OFS_CTRL: begin
          next_global        = wdata[`FIC_CTRL_GLOBAL_BIT];
          next_tx_to_sysflag = wdata[`FIC_CTRL_TXSF_BIT];
          next_trigger       = wdata[`FIC_CTRL_TRIG_LSB +: 4];
        end
        `FIC_OFS_ENABLE:     next_enable     = wdata[NSRC-1:0];
        `FIC_OFS_PRIO_LOW:   next_prio_low   = wdata[NSRC-1:0];
        `FIC_OFS_PRIO_HIGH:  next_prio_high  = wdata[NSRC-1:0];
        `FIC_OFS_EVT_ENABLE: next_evt_enable = wdata[`FIC_NEVT-1:0];
        default: begin
        end
      endcase
    end
    next_rdata = '0;
    if (rd) begin
      case (addr)
        `FIC_OFS_CTRL: begin
          next_rdata[`FIC_CTRL_GLOBAL_BIT]      = global_irq_enable;
          next_rdata[`FIC_CTRL_TXSF_BIT]        = tx_to_sysflag;
          next_rdata[`FIC_CTRL_TRIG_LSB +: 4]   = ext_trigger_type;
        end
        `FIC_OFS_ENABLE:     next_rdata[NSRC-1:0] = enable;
        `FIC_OFS_PRIO_LOW:   next_rdata[NSRC-1:0] = prio_low;
        `FIC_OFS_PRIO_HIGH:  next_rdata[NSRC-1:0] = prio_high;
        `FIC_OFS_FLAGS: begin
          next_rdata[`FIC_FLAGS_EXT_LSB +: 4] = ext_request_flag;
          next_rdata[`FIC_FLAGS_TMR_LSB +: 2] = timer_overflow_flag;
        end
        `FIC_OFS_PENDING:    next_rdata[NSRC-1:0] = src;
        `FIC_OFS_ACTIVE: begin
          next_rdata[`FIC_ACT_INSVC_LSB +: 4] = in_service;
          next_rdata[`FIC_ACT_IDX_LSB +: 5]   = vec.idx;
        end
        `FIC_OFS_EVT_STATUS: next_rdata[`FIC_NEVT-1:0] = evt_status;
        `FIC_OFS_EVT_ENABLE: next_rdata[`FIC_NEVT-1:0] = evt_enable;
        default:             next_rdata = '0;
      endcase
    end
    next_irq_out = |(next_evt_status & next_evt_enable);
  end

  // ---------------- registers
  always_ff @(posedge clk) begin
    if (srst) begin
      global_irq_enable   <= 1'b0;
      tx_to_sysflag       <= 1'b0;
      ext_trigger_type    <= 4'h0;
      enable              <= '0;
      prio_low            <= '0;
      prio_high           <= '0;
      ext_request_flag    <= 4'h0;
      timer_overflow_flag <= 2'h0;
      pin_q               <= 4'hf;
      in_service          <= 4'h0;
      evt_status          <= '0;
      evt_enable          <= '0;
      rdata               <= `FIC_RST_WORD;
      irq_out             <= 1'b0;
      vec                 <= '0;
    end else if (ce) begin
      global_irq_enable   <= next_global;
      tx_to_sysflag       <= next_tx_to_sysflag;
      ext_trigger_type    <= next_trigger;
      enable              <= next_enable;
      prio_low            <= next_prio_low;
      prio_high           <= next_prio_high;
      ext_request_flag    <= next_ext_flag;
      timer_overflow_flag <= next_tmr_flag;
      pin_q               <= next_pin_q;
      in_service          <= next_in_service;
      evt_status          <= next_evt_status;
      evt_enable          <= next_evt_enable;
      rdata               <= next_rdata;
      irq_out             <= next_irq_out;
      vec                 <= next_vec;
    end
  end

endmodule

`default_nettype wire

/* File: dv/fic_top_asserts.sv */
// port-level checks of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "fic_map.svh"
module fic_top_checker #(
  parameter int NSRC = `FIC_NSRC
) (
  input wire logic                   clk,       // core clock
  input wire logic                   srst,      // synchronous reset
  input wire logic                   ce,        // clock enable
  input wire logic [`FIC_ADDR_W-1:0] addr,      // register address
  input wire logic [`FIC_DATA_W-1:0] wdata,     // write data
  input wire logic                   wr,        // write strobe
  input wire logic                   rd,        // read strobe
  input wire logic [`FIC_DATA_W-1:0] rdata,     // read data
  input wire fic_pkg::fic_vector_t   vec,       // vector to the core
  input wire logic                   core_ack,  // core takes vector
  input wire logic                   core_reti, // core returns
  input wire logic                   irq_out    // event interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // level of the last taken vector; dropped on a return unless an ack lands in that cycle, so nested checks stay safe
  logic                svc, next_svc;
  fic_pkg::fic_level_t lvl, next_lvl;
  always_comb begin
    next_svc = svc;
    next_lvl = lvl;
    if (ce && core_ack && vec.req) begin
      next_svc = 1'b1;
      next_lvl = vec.level;
    end else if (ce && core_reti) begin
      next_svc = 1'b0;
    end
    if (srst) begin
      next_svc = 1'b0;
      next_lvl = '0;
    end
  end
  always_ff @(posedge clk) begin
    svc <= next_svc;
    lvl <= next_lvl;
  end

  chk_rd_idle: assert property (ce && !rd |=> rdata == '0)
    else $error("read data not zero outside a read");
  chk_ack_drop: assert property (ce && core_ack && vec.req |=> !vec.req)
    else $error("request still up after ack");
  chk_vec_addr: assert property (
    vec.req |-> vec.addr == `FIC_VEC_BASE + {8'h00, vec.idx, 3'b000})
    else $error("vector address wrong");
  chk_idx_range: assert property (vec.req |-> vec.idx < NSRC)
    else $error("source index out of range");
  chk_preempt_higher: assert property (svc && vec.req |-> vec.level > lvl)
    else $error("request presented at a level not above service");
  chk_rst_quiet: assert property ($fell(srst) |-> vec == '0 && !irq_out && rdata == '0)
    else $error("outputs not idle after reset");
  chk_ce_freeze: assert property (!ce |=> $stable(vec) && $stable(rdata) && $stable(irq_out))
    else $error("outputs moved with clock enable low");
  chk_evt_clear: assert property ((ce && wr && addr == 8'h24 && wdata[2:0] == 3'h7
    && !core_ack && !core_reti) ##1 (ce && !core_ack && !core_reti) |=> !irq_out)
    else $error("event interrupt stays after clear");
endmodule
bind fic_top fic_top_checker #(.NSRC(NSRC)) chk_u (
  .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .vec(vec), .core_ack(core_ack), .core_reti(core_reti), .irq_out(irq_out));
`default_nettype wire

/* File: dv/fic_core_model.sv */
// processor core model: takes presented vectors, returns on command
`timescale 1ns/100ps
`default_nettype none
module fic_core_model (
  input  wire logic                 clk,    // core clock
  input  wire logic                 run,    // accept vectors
  input  wire logic [1:0]           dly,    // cycles before ack
  input  wire logic                 ret_go, // finish current routine
  input  wire fic_pkg::fic_vector_t vec,    // presented vector
  output logic                      ack,    // vector taken
  output logic                      reti    // routine done
);
  logic [1:0] wait_cnt;
  initial begin
    ack = 1'b0;
    reti = 1'b0;
    wait_cnt = 2'h0;
  end
  // ack is a one-cycle pulse; a vector that vanishes meanwhile simply loses it
  always @(posedge clk) begin
    reti <= ret_go;
    ack <= 1'b0;
    if (!run || !vec.req || ack) begin
      wait_cnt <= 2'h0;
    end else if (wait_cnt == dly) begin
      ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/fic_top_tb.sv */
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module fic_top_tb;
  logic                       clk, srst, ce, wr, rd, t0r, t1r, run, ret_go, ge;
  logic                       core_ack, core_reti, irq_out;
  logic [7:0]                 addr;
  logic [31:0]                wdata, rdata, v;
  logic [3:0]                 pin;
  logic [1:0]                 dly;
  logic [23:0]                en, lo, hi, g;
  logic [5:0]                 fl;
  logic [63:0]                pv;
  fic_pkg::fic_periph_flags_t periph, p;
  fic_pkg::fic_vector_t       vec;
  int                         err_total, num_checks, cyc, b;

  fic_top dut_u (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ext_irq_pin_0(pin[0]), .ext_irq_pin_1(pin[1]),
    .ext_irq_pin_2(pin[2]), .ext_irq_pin_3(pin[3]), .timer0_rollover(t0r),
    .timer1_rollover(t1r), .periph(periph), .vec(vec), .core_ack(core_ack),
    .core_reti(core_reti), .irq_out(irq_out));
  fic_core_model core_u (.clk(clk), .run(run), .dly(dly), .ret_go(ret_go), .vec(vec),
    .ack(core_ack), .reti(core_reti));

  always #20 clk = ~clk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      err_total++;
      stop_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one idle cycle after each strobe keeps every drive to one assignment per step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic wait_ack;
    for (int k = 0; k < 20 && core_ack !== 1'b1; k++) @(posedge clk);
    chk("ack", core_ack, 1'b1);
  endtask

  task automatic ret;
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // source request vector, bit 0 is source #1
  function automatic logic [23:0] exp_src(input fic_pkg::fic_periph_flags_t q,
                                          input logic [5:0] f);
    return {q.comp2_flag, q.twi1_flag, |q.pca1_flags, |q.serial3_flags, |q.timer4_flags,
      |q.serial2_flags, q.comp1_flag, |q.timer3_flags, q.comp0_flag, q.twsi_flag,
      q.keypad_flag, |q.serial1_flags, |{q.watchdog_event_flag, q.brownout0_flag,
      q.brownout1_flag, q.rtc_overflow_flag, q.missing_clock_flag,
      q.serial_start_detect_flag, q.serial_stop_detect_flag}, |q.pca0_flags, q.adc_flag,
      q.spi_flag, f[3], f[2], |q.timer2_flags, q.serial0_rx_flag | q.serial0_tx_flag,
      f[5], f[1], f[4], f[0]};
  endfunction

  initial begin
    void'($urandom(32'hb30c8891));
    clk = 1'b0; srst = 1'b1; ce = 1'b1; addr = 8'h00; wdata = '0; wr = 1'b0; rd = 1'b0;
    pin = 4'hf; t0r = 1'b0; t1r = 1'b0; periph = '0; run = 1'b0; dly = 2'h0; ret_go = 1'b0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a <= 'h40; a += 4) begin
      rd_reg(8'(a), v);
      chk("reset_read", v, 32'h0);
    end
    repeat (60) begin
      en = 24'($urandom); lo = 24'($urandom); hi = 24'($urandom); fl = 6'($urandom);
      pv = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
      p = pv[44:0];
      ge = ($urandom % 4) != 0;
      periph <= p;
      wr_reg(8'h00, {24'h0, 4'hf, 3'h0, ge});
      wr_reg(8'h04, {8'h0, en});
      wr_reg(8'h08, {8'h0, lo});
      wr_reg(8'h0c, {8'h0, hi});
      wr_reg(8'h10, {26'h0, fl});
      wr_reg(8'h14, $urandom);
      ce <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      g = exp_src(p, fl) & en & {24{ge}};
      b = -1;
      for (int i = 0; i < 24; i++)
        if (g[i] && (b < 0 || {hi[i], lo[i]} > {hi[b], lo[b]})) b = i;
      chk("req", vec.req, b >= 0);
      if (b >= 0) begin
        chk("idx", vec.idx, b);
        chk("addr", vec.addr, 16'h0003 + 16'(b * 8));
        chk("level", vec.level, {hi[b], lo[b]});
      end
      rd_reg(8'h14, v);
      chk("pending", v, {8'h0, exp_src(p, fl)});
    end
    p = '0;
    p.serial0_tx_flag = 1'b1;
    periph <= p;
    wr_reg(8'h00, 32'h3);
    wr_reg(8'h04, 32'h800);
    repeat (2) @(posedge clk);
    chk("sys_tx", {vec.req, vec.idx}, 6'h2b);
    periph <= '0;
    wr_reg(8'h08, 32'h40);
    wr_reg(8'h0c, 32'h40);
    wr_reg(8'h04, 32'h5f);
    wr_reg(8'h20, 32'h1);
    wr_reg(8'h00, 32'hb1);
    wr_reg(8'h10, 32'h0);
    run <= 1'b1;
    dly <= 2'h2;
    pin[1] <= 1'b0;
    wait_ack;
    pin[1] <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(8'h10, v);
    chk("ext1_clr", v[5:0], 6'h0);
    rd_reg(8'h18, v);
    chk("insvc", v[3:0], 4'h1);
    chk("irq_on", irq_out, 1'b1);
    t0r <= 1'b1;
    @(posedge clk);
    t0r <= 1'b0;
    repeat (4) @(posedge clk);
    chk("no_preempt", vec.req, 1'b0);
    dly <= 2'h0;
    pin[2] <= 1'b0;
    wait_ack;
    repeat (2) @(posedge clk);
    rd_reg(8'h18, v);
    chk("nested", v[3:0], 4'h9);
    rd_reg(8'h10, v);
    chk("lvl_kept", v[5:0], 6'h14);
    pin[2] <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(8'h10, v);
    chk("lvl_gone", v[5:0], 6'h10);
    ret;
    ret;
    wait_ack;
    repeat (2) @(posedge clk);
    rd_reg(8'h10, v);
    chk("tmr0_clr", v[5:0], 6'h0);
    ret;
    t1r <= 1'b1;
    @(posedge clk);
    t1r <= 1'b0;
    wait_ack;
    repeat (2) @(posedge clk);
    rd_reg(8'h10, v);
    chk("tmr1_clr", v[5:0], 6'h0);
    ret;
    p = '0;
    p.serial0_rx_flag = 1'b1;
    periph <= p;
    wait_ack;
    run <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(8'h14, v);
    chk("rx_kept", v[4], 1'b1);
    periph <= '0;
    ret;
    rd_reg(8'h1c, v);
    chk("evt", v[2:0], 3'h3);
    wr_reg(8'h24, 32'h7);
    @(posedge clk);
    chk("irq_clr", irq_out, 1'b0);
    ret;
    rd_reg(8'h1c, v);
    chk("bad_ret", v[2:0], 3'h4);
    chk("irq_mask", irq_out, 1'b0);
    wr_reg(8'h20, 32'h7);
    @(posedge clk);
    chk("irq_unmask", irq_out, 1'b1);
    wr_reg(8'h24, 32'h7);
    @(posedge clk);
    chk("irq_off", irq_out, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire
